// *** tcm_timer16.sv ***
// Top of the 16-bit compare timer with APB registers and pin override
`timescale 1ns/100ps
module tcm_timer16 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tcm_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chan_a_pin_out,
   output logic chan_a_pin_oe,
   output logic chan_b_pin_out,
   output logic chan_b_pin_oe
);
   import tcm_pkg::*;

   logic [3:0] waveform_mode_field;
   logic [1:0] compare_output_mode_bits [2];
   logic [2:0] presc_sel;
   logic [CNT_W-1:0] counter_value;
   logic [CNT_W-1:0] channel_compare_value [2];
   logic [CNT_W-1:0] capture_value_reg;
   logic [3:0] flags;
   logic [1:0] output_pin_direction_bit;
   logic [1:0] port_latch;
   logic [1:0] compare_output_state;
   logic [1:0] pin_out_q;
   logic [1:0] pin_oe_q;
   logic [10:0] presc_cnt;
   logic [10:0] presc_div;
   logic tick;
   logic block_pending;
   logic wr_en;
   logic wr_ctrl;
   logic wr_count;
   logic wr_force;
   logic wr_ostate;
   logic wr_flags;
   logic pwm_mode;
   logic ctc_mode;
   logic [CNT_W-1:0] top_value;
   logic ctc_hit;
   logic ovf_set;
   logic [1:0] match_evt;
   logic [1:0] force_evt;
   logic [31:0] rd_word;
   logic rd_ok;

   // Bus decode
   assign wr_en = psel && penable && pwrite && pready;
   assign wr_ctrl = wr_en && paddr == OFF_CTRL;
   assign wr_count = wr_en && paddr == OFF_COUNT;
   assign wr_force = wr_en && paddr == OFF_FORCE;
   assign wr_ostate = wr_en && paddr == OFF_OSTATE;
   assign wr_flags = wr_en && paddr == OFF_FLAGS;

   // Mode decode
   assign ctc_mode = waveform_mode_field == WGM_CTC_CMP || waveform_mode_field == WGM_CTC_CAP;
   assign pwm_mode = !(waveform_mode_field == WGM_NORMAL || ctc_mode
                       || waveform_mode_field == WGM_RESV);
   assign top_value = (waveform_mode_field == WGM_CTC_CAP) ? capture_value_reg
                      : channel_compare_value[0];

   // Matches and clears
   assign ctc_hit = tick && !block_pending && !wr_count && ctc_mode
                    && counter_value == top_value;
   assign ovf_set = tick && !wr_count && counter_value == CNT_MAX;

   // Control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         waveform_mode_field <= WGM_RST;
         compare_output_mode_bits[0] <= 2'h0;
         compare_output_mode_bits[1] <= 2'h0;
         presc_sel <= PSEL_RST;
      end
      else if (wr_ctrl)
      begin
         waveform_mode_field <= pwdata[CTRL_WGM_LSB +: 4];
         compare_output_mode_bits[0] <= pwdata[CTRL_COMA_LSB +: 2];
         compare_output_mode_bits[1] <= pwdata[CTRL_COMB_LSB +: 2];
         presc_sel <= pwdata[CTRL_PSEL_LSB +: 3];
      end
   end

   // Prescaler divisor
   always_comb
   begin
      case (presc_sel)
         3'h1: presc_div = DIV_1;
         3'h2: presc_div = DIV_8;
         3'h3: presc_div = DIV_64;
         3'h4: presc_div = DIV_256;
         3'h5: presc_div = DIV_1024;
         default: presc_div = 11'h000;
      endcase
   end

   // One-cycle timer tick
   assign tick = presc_div != 11'h000 && presc_cnt == presc_div - 11'h001;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc_cnt <= 11'h000;
      else if (tick || presc_div == 11'h000 || wr_ctrl)
         presc_cnt <= 11'h000;
      else
         presc_cnt <= presc_cnt + 11'h001;
   end

   // Counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         counter_value <= CNT_RST;
      else if (wr_count)
         counter_value <= pwdata[CNT_W-1:0];
      else if (tick)
      begin
         if (ctc_hit)
            counter_value <= CNT_RST;
         else
            counter_value <= counter_value + 16'h0001;
      end
   end

   // Match blocking after counter write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         block_pending <= 1'b0;
      else if (wr_count)
         block_pending <= 1'b1;
      else if (tick)
         block_pending <= 1'b0;
   end

   // Compare and capture registers, written straight through
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         channel_compare_value[0] <= CNT_RST;
         channel_compare_value[1] <= CNT_RST;
         capture_value_reg <= CNT_RST;
      end
      else if (wr_en)
      begin
         if (paddr == OFF_CMPA)
            channel_compare_value[0] <= pwdata[CNT_W-1:0];
         if (paddr == OFF_CMPB)
            channel_compare_value[1] <= pwdata[CNT_W-1:0];
         if (paddr == OFF_CAPT)
            capture_value_reg <= pwdata[CNT_W-1:0];
      end
   end

   // Flags, set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags <= FLAGS_RST;
      else
      begin
         flags[FLG_OVF] <= ovf_set
                           || (flags[FLG_OVF] && !(wr_flags && pwdata[FLG_OVF]));
         flags[FLG_CMPA] <= match_evt[0]
                            || (flags[FLG_CMPA] && !(wr_flags && pwdata[FLG_CMPA]));
         flags[FLG_CMPB] <= match_evt[1]
                            || (flags[FLG_CMPB] && !(wr_flags && pwdata[FLG_CMPB]));
         flags[FLG_CAP] <= (ctc_hit && waveform_mode_field == WGM_CTC_CAP)
                           || (flags[FLG_CAP] && !(wr_flags && pwdata[FLG_CAP]));
      end
   end

   // Port direction and latch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         output_pin_direction_bit <= PORT_RST;
         port_latch <= PORT_RST;
      end
      else if (wr_en && paddr == OFF_PORTCTL)
      begin
         output_pin_direction_bit <= pwdata[PORT_DIR_LSB +: 2];
         port_latch <= pwdata[PORT_LATCH_LSB +: 2];
      end
   end

   // Output channels and pin override
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_chan
         assign match_evt[gi] = tick && !block_pending && !wr_count
                                && counter_value == channel_compare_value[gi];
         assign force_evt[gi] = wr_force && pwdata[gi] && !pwm_mode;

         tcm_out_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .match_evt(match_evt[gi]),
            .force_evt(force_evt[gi]),
            .mode_bits(compare_output_mode_bits[gi]),
            .pwm_mode(pwm_mode),
            .ctc_mode(ctc_mode),
            .load_en(wr_ostate),
            .load_val(pwdata[gi]),
            .state(compare_output_state[gi])
         );

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pin_out_q[gi] <= 1'b0;
               pin_oe_q[gi] <= 1'b0;
            end
            else
            begin
               pin_out_q[gi] <= (compare_output_mode_bits[gi] != 2'h0)
                                ? compare_output_state[gi] : port_latch[gi];
               pin_oe_q[gi] <= output_pin_direction_bit[gi];
            end
         end
      end
   endgenerate

   assign chan_a_pin_out = pin_out_q[0];
   assign chan_a_pin_oe = pin_oe_q[0];
   assign chan_b_pin_out = pin_out_q[1];
   assign chan_b_pin_oe = pin_oe_q[1];

   // Read mux
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (paddr)
         OFF_CTRL: rd_word = {21'h0, presc_sel, compare_output_mode_bits[1],
                              compare_output_mode_bits[0], waveform_mode_field};
         OFF_COUNT: rd_word = {16'h0, counter_value};
         OFF_CMPA: rd_word = {16'h0, channel_compare_value[0]};
         OFF_CMPB: rd_word = {16'h0, channel_compare_value[1]};
         OFF_CAPT: rd_word = {16'h0, capture_value_reg};
         OFF_FLAGS: rd_word = {28'h0, flags};
         OFF_FORCE: rd_word = 32'h0000_0000;
         OFF_OSTATE: rd_word = {30'h0, compare_output_state};
         OFF_PORTCTL: rd_word = {28'h0, port_latch, output_pin_direction_bit};
         default: rd_ok = 1'b0;
      endcase
   end

   // APB answer, zero wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !rd_ok;
         if (psel && !penable && !pwrite)
            prdata <= rd_word;
      end
   end

   sequence s_tick_at_max;
      tick && !wr_count && counter_value == CNT_MAX;
   endsequence

   sequence s_top_hit;
      ctc_hit && !wr_count;
   endsequence

   sequence s_blocked_tick;
      tick && block_pending && !wr_count;
   endsequence

   AST_PIN_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> chan_a_pin_out == ($past(compare_output_mode_bits[0]) != 2'h0
         ? $past(compare_output_state[0]) : $past(port_latch[0])))
      else $error("pin source selection wrong");
   AST_PIN_DIR: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> chan_b_pin_oe == $past(output_pin_direction_bit[1]))
      else $error("pin enable not following direction bit");
   AST_NORMAL_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      s_tick_at_max and waveform_mode_field == WGM_NORMAL
      |=> counter_value == CNT_RST && flags[FLG_OVF])
      else $error("normal mode wrap or overflow flag wrong");
   AST_OVF_CTC: assert property (@(posedge pclk) disable iff (!presetn)
      s_tick_at_max and ctc_mode |=> flags[FLG_OVF])
      else $error("overflow flag missing at max to zero");
   AST_CTC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_top_hit |=> counter_value == CNT_RST)
      else $error("counter not cleared at top");
   AST_CAP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      s_top_hit and waveform_mode_field == WGM_CTC_CAP |=> flags[FLG_CAP])
      else $error("capture flag not raised at top");
   AST_CMP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      tick && !block_pending && !wr_count && counter_value == channel_compare_value[1]
      |=> flags[FLG_CMPB])
      else $error("compare flag not set on match");
   AST_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      s_blocked_tick and ctc_mode |=> counter_value != CNT_RST
         || $past(counter_value) == CNT_MAX)
      else $error("counter cleared by blocked match");
   AST_FORCE_NOFLAG: assert property (@(posedge pclk) disable iff (!presetn)
      wr_force && !match_evt[0] && !flags[FLG_CMPA] |=> !flags[FLG_CMPA])
      else $error("force strobe set the compare flag");
   AST_COUNT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count |=> counter_value == $past(pwdata[CNT_W-1:0]))
      else $error("counter write not taken");

   // Blocking, hold and bus answer checks
   AST_BLOCK_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      s_blocked_tick and !flags[FLG_CMPA] |=> !flags[FLG_CMPA])
      else $error("blocked match set the compare flag");
   AST_HOLD_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn)
      !tick && !wr_count |=> $stable(counter_value))
      else $error("counter moved without a tick");
   AST_OVF_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      flags[FLG_OVF] && !(wr_flags && pwdata[FLG_OVF]) |=> flags[FLG_OVF])
      else $error("overflow flag lost without a clear");
   AST_CAP_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      !flags[FLG_CAP] && waveform_mode_field != WGM_CTC_CAP |=> !flags[FLG_CAP])
      else $error("capture flag raised outside capture top mode");
   AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("no answer after setup cycle");
   AST_APB_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held beyond one cycle");
endmodule

// *** tcm_pkg.sv ***
// Constants and types shared by the 16-bit compare timer
package tcm_pkg;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_CMPA = 8'h08;
   localparam logic [7:0] OFF_CMPB = 8'h0c;
   localparam logic [7:0] OFF_CAPT = 8'h10;
   localparam logic [7:0] OFF_FLAGS = 8'h14;
   localparam logic [7:0] OFF_FORCE = 8'h18;
   localparam logic [7:0] OFF_OSTATE = 8'h1c;
   localparam logic [7:0] OFF_PORTCTL = 8'h20;
   localparam int CTRL_WGM_LSB = 0;
   localparam int CTRL_COMA_LSB = 4;
   localparam int CTRL_COMB_LSB = 6;
   localparam int CTRL_PSEL_LSB = 8;
   localparam int FLG_OVF = 0;
   localparam int FLG_CMPA = 1;
   localparam int FLG_CMPB = 2;
   localparam int FLG_CAP = 3;
   localparam int PORT_DIR_LSB = 0;
   localparam int PORT_LATCH_LSB = 2;
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_CTC_CMP = 4'h4;
   localparam logic [3:0] WGM_CTC_CAP = 4'hc;
   localparam logic [3:0] WGM_RESV = 4'hd;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [3:0] WGM_RST = 4'h0;
   localparam logic [2:0] PSEL_RST = 3'h0;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [1:0] PORT_RST = 2'h0;
   localparam logic [10:0] DIV_1 = 11'h001;
   localparam logic [10:0] DIV_8 = 11'h008;
   localparam logic [10:0] DIV_64 = 11'h040;
   localparam logic [10:0] DIV_256 = 11'h100;
   localparam logic [10:0] DIV_1024 = 11'h400;
   typedef enum logic [1:0]
   {
      COM_NONE = 2'h0,
      COM_TOGGLE = 2'h1,
      COM_CLEAR = 2'h2,
      COM_SET = 2'h3
   } tcm_com_t;
endpackage

// *** tcm_out_chan.sv ***
// One compare output state bit with its match and force actions
`timescale 1ns/100ps
module tcm_out_chan (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic match_evt,
   input wire logic force_evt,
   input wire logic [1:0] mode_bits,
   input wire logic pwm_mode,
   input wire logic ctc_mode,
   input wire logic load_en,
   input wire logic load_val,
   output logic state
);
   import tcm_pkg::*;

   // Output state update
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= 1'b0;
      else if (load_en)
         state <= load_val;
      else if (!pwm_mode && (match_evt || force_evt))
      begin
         case (tcm_com_t'(mode_bits))
            COM_TOGGLE: state <= ~state;
            COM_CLEAR: state <= 1'b0;
            COM_SET: state <= 1'b1;
            default: state <= state;
         endcase
      end
   end

   sequence s_act;
      !load_en && !pwm_mode && (match_evt || force_evt);
   endsequence

   AST_RESET_CLEAR: assert property (@(posedge pclk) $rose(presetn) |-> !state)
      else $error("output state not zero after reset");
   AST_MODE0_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      s_act and mode_bits == 2'h0 |=> $stable(state))
      else $error("output state moved with mode zero");
   AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
      s_act and mode_bits == 2'h1 and ctc_mode |=> state != $past(state))
      else $error("toggle mode did not invert state");
   AST_SET_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_act and mode_bits[1] |=> state == $past(mode_bits[0]))
      else $error("set or clear action wrong");
   AST_PWM_NOACT: assert property (@(posedge pclk) disable iff (!presetn)
      !load_en && pwm_mode |=> $stable(state))
      else $error("state moved in unsupported mode");
endmodule

// *** tcm_pin_load.sv ***
// External load on a compare output pin: pull-up and edge interval timer
`timescale 1ns/100ps
module tcm_pin_load (
   input wire logic pclk,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic level,
   output logic [31:0] gap,
   output logic [31:0] edges
);
   logic prev;
   logic [31:0] cnt;
   // Pin only follows the block while driven, else pulled high
   assign level = pin_oe ? pin_out : 1'b1;
   initial
   begin
      prev = 1'b1;
      cnt = 32'h0;
      gap = 32'h0;
      edges = 32'h0;
   end
   // Clock cycles between level changes
   always @(posedge pclk)
   begin
      prev <= level;
      if (level !== prev)
      begin
         gap <= cnt;
         cnt <= 32'h1;
         edges <= edges + 32'h1;
      end
      else
         cnt <= cnt + 32'h1;
   end
endmodule

// *** tcm_timer16_bench.sv ***
// Self-checking bench for the 16-bit compare timer
`timescale 1ns/100ps
module tcm_timer16_bench;
   import tcm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, a_out, a_oe, b_out, b_oe, a_lvl;
   logic [31:0] a_gap, a_edges, rdat;
   logic rerr;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   tcm_timer16 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_a_pin_out(a_out), .chan_a_pin_oe(a_oe),
      .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe));
   tcm_pin_load load_a (.pclk(pclk), .pin_out(a_out), .pin_oe(a_oe), .level(a_lvl),
      .gap(a_gap), .edges(a_edges));
   always #10 pclk = ~pclk;
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   function automatic logic [31:0] cv(input logic [3:0] m, input logic [1:0] ca,
      input logic [2:0] ps);
      return {21'h0, ps, 2'h0, ca, m};
   endfunction
   task automatic settle;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic run_for(input int n);
      wr(OFF_CTRL, rdat);
      repeat (n) @(posedge pclk);
   endtask
   task automatic t_reset;
      rd_chk(OFF_OSTATE, 32'h0);
      rd_chk(OFF_FLAGS, 32'h0);
      rd_chk(OFF_COUNT, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk({31'h0, a_oe}, 32'h0);
   endtask
   task automatic t_pin;
      wr(OFF_OSTATE, 32'h1);
      wr(OFF_PORTCTL, 32'h0);
      settle();
      chk({31'h0, a_lvl}, 32'h1);
      wr(OFF_PORTCTL, 32'h1);
      settle();
      chk({30'h0, a_oe, a_out}, 32'h2);
      wr(OFF_CTRL, cv(WGM_NORMAL, COM_TOGGLE, 3'h0));
      settle();
      chk({30'h0, a_oe, a_lvl}, 32'h3);
      wr(OFF_PORTCTL, 32'hb);
      settle();
      chk({28'h0, b_oe, b_out, a_oe, a_lvl}, 32'hf);
   endtask
   task automatic t_force;
      logic [1:0] c;
      logic s, e;
      wr(OFF_COUNT, 32'h7);
      for (int i = 0; i < 8; i++)
      begin
         c = i[2:1];
         s = i[0];
         e = (c == 2'h0) ? s : (c == 2'h1) ? ~s : c[0];
         wr(OFF_CTRL, cv(WGM_NORMAL, c, 3'h0));
         wr(OFF_OSTATE, {31'h0, s});
         wr(OFF_FORCE, 32'h1);
         rd_chk(OFF_OSTATE, {31'h0, e});
      end
      rd_chk(OFF_FLAGS, 32'h0);
      rd_chk(OFF_COUNT, 32'h7);
      wr(OFF_CTRL, cv(4'h5, COM_TOGGLE, 3'h0));
      wr(OFF_FORCE, 32'h1);
      rd_chk(OFF_OSTATE, 32'h1);
   endtask
   task automatic t_block;
      wr(OFF_CTRL, cv(WGM_NORMAL, COM_NONE, 3'h0));
      wr(OFF_CMPA, 32'h5);
      wr(OFF_COUNT, 32'h5);
      wr(OFF_FLAGS, 32'hf);
      rdat = cv(WGM_NORMAL, COM_NONE, 3'h1);
      run_for(10);
      wr(OFF_CTRL, cv(WGM_NORMAL, COM_NONE, 3'h0));
      rd_chk(OFF_FLAGS, 32'h0);
      wr(OFF_COUNT, 32'h2);
      rdat = cv(WGM_NORMAL, COM_NONE, 3'h1);
      run_for(10);
      wr(OFF_CTRL, cv(WGM_NORMAL, COM_NONE, 3'h0));
      rd_chk(OFF_FLAGS, 32'h2);
      wr(OFF_FLAGS, 32'h2);
      rd_chk(OFF_FLAGS, 32'h0);
   endtask
   task automatic t_wrap(input logic [3:0] m, input logic [31:0] ef, input logic [15:0] lim);
      wr(OFF_CTRL, cv(m, COM_NONE, 3'h0));
      wr(OFF_CMPA, 32'h2);
      wr(OFF_COUNT, 32'hfff0);
      wr(OFF_FLAGS, 32'hf);
      rdat = cv(m, COM_NONE, 3'h1);
      run_for(40);
      wr(OFF_CTRL, cv(m, COM_NONE, 3'h0));
      rd_chk(OFF_FLAGS, ef);
      apb(1'b0, OFF_COUNT, 32'h0);
      chk({31'h0, rdat[15:0] <= lim}, 32'h1);
   endtask
   task automatic t_wave(input logic [3:0] m, input logic [2:0] ps, input logic [31:0] hp);
      logic [31:0] e0;
      wr(OFF_CTRL, cv(m, COM_TOGGLE, ps));
      e0 = a_edges;
      while (a_edges - e0 < 32'h3)
         @(posedge pclk);
      chk(a_gap, hp);
   endtask
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pin();
      t_force();
      t_block();
      t_wrap(WGM_NORMAL, 32'h7, 16'h0040);
      t_wrap(WGM_CTC_CMP, 32'h7, 16'h0002);
      wr(OFF_CMPA, 32'h3);
      wr(OFF_COUNT, 32'h0);
      t_wave(WGM_CTC_CMP, 3'h1, 32'd4);
      t_wave(WGM_CTC_CMP, 3'h2, 32'd32);
      t_wave(WGM_CTC_CMP, 3'h3, 32'd256);
      t_wave(WGM_CTC_CMP, 3'h4, 32'd1024);
      t_wave(WGM_CTC_CMP, 3'h5, 32'd4096);
      wr(OFF_CTRL, cv(WGM_CTC_CAP, COM_NONE, 3'h0));
      wr(OFF_CAPT, 32'h4);
      wr(OFF_CMPA, 32'h1);
      wr(OFF_COUNT, 32'h0);
      wr(OFF_FLAGS, 32'hf);
      t_wave(WGM_CTC_CAP, 3'h1, 32'd5);
      apb(1'b0, OFF_FLAGS, 32'h0);
      chk({31'h0, rdat[FLG_CAP]}, 32'h1);
      summarize();
   end
endmodule
